// ---- src/rtc_ctrl.sv ----
// Control register, 32-bit counter, alarm and missing-clock detector.
// Assumes the slow oscillator output arrives as an asynchronous pin and
// software reaches registers through a simple indirect address port.
`timescale 1ns/1ps
module rtc_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Slow oscillator
   input wire logic slow_osc_in,
   output logic slow_osc_enable,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Events
   output logic alarm_event,
   output logic osc_failure_flag
);
   typedef struct packed {
      logic slow_osc_enable;
      logic missing_clock_detect_enable;
      logic osc_failure_flag;
      logic counter_run;
      logic alarm_enable;
      logic alarm_flag;
      logic autoreset;
      logic counter_load_request;
      logic counter_snapshot_request;
      logic [31:0] counter;
      logic [31:0] holding;
      logic [31:0] match;
      logic [rtc_ctrl_pkg::MCD_W-1:0] idle_cnt;
      logic [1:0] sync;
      logic prev;
      logic [7:0] rdata;
   } state_t;

   state_t r;
   state_t next_r;
   logic tick;
   logic level_change;
   logic [7:0] ctrl_view;
   logic [7:0] rd_view;
   logic ctrl_sel;
   logic [3:0] hold_sel;
   logic [3:0] match_sel;
   logic [7:0] hold_byte [4];
   logic [7:0] match_byte [4];
   logic idle_full;
   logic fail_set;
   logic [rtc_ctrl_pkg::MCD_W-1:0] next_idle;
   logic [31:0] next_count;

   assign ctrl_sel = reg_addr == rtc_ctrl_pkg::CTRL_ADDR;

   // Byte lanes of the holding and match words, byte 0 is the LSB
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign hold_sel[lane] =
            reg_addr == rtc_ctrl_pkg::HOLD0_ADDR + 8'(lane);
         assign match_sel[lane] =
            reg_addr == rtc_ctrl_pkg::MATCH0_ADDR + 8'(lane);
         assign hold_byte[lane] = r.holding[8*lane +: 8];
         assign match_byte[lane] = r.match[8*lane +: 8];
      end
   endgenerate

   // Control register as software reads it
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[rtc_ctrl_pkg::OSC_EN_BIT] = r.slow_osc_enable;
      ctrl_view[rtc_ctrl_pkg::MCD_EN_BIT] = r.missing_clock_detect_enable;
      ctrl_view[rtc_ctrl_pkg::OSC_FAIL_BIT] = r.osc_failure_flag;
      ctrl_view[rtc_ctrl_pkg::RUN_BIT] = r.counter_run;
      ctrl_view[rtc_ctrl_pkg::ALARM_EN_BIT] = r.alarm_enable;
      ctrl_view[rtc_ctrl_pkg::ALARM_AR_BIT] = r.alarm_flag;
      ctrl_view[rtc_ctrl_pkg::LOAD_BIT] = r.counter_load_request;
      ctrl_view[rtc_ctrl_pkg::SNAP_BIT] = r.counter_snapshot_request;
   end

   assign level_change = r.sync[1] ^ r.prev;
   // Slow edges only count while the oscillator is enabled
   assign tick = r.sync[1] & ~r.prev & r.slow_osc_enable;

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_view = 8'h00;
      if (ctrl_sel) begin
         rd_view = ctrl_view;
      end
      for (int k = 0; k < 4; k++) begin
         if (hold_sel[k]) begin
            rd_view = hold_byte[k];
         end
         if (match_sel[k]) begin
            rd_view = match_byte[k];
         end
      end
   end

   // Missing-clock detector counts mclk cycles with no pin change
   assign idle_full = r.idle_cnt == rtc_ctrl_pkg::MCD_CYCLES;
   assign fail_set = r.missing_clock_detect_enable && r.slow_osc_enable &&
                     idle_full;

   always_comb begin
      next_idle = r.idle_cnt;
      if (!r.missing_clock_detect_enable || level_change) begin
         next_idle = '0;
      end else if (!idle_full) begin
         next_idle = r.idle_cnt + 13'h0001;
      end
   end

   // Counter step on a slow tick: load first, then auto-reset, then run
   always_comb begin
      next_count = r.counter;
      if (r.counter_load_request) begin
         next_count = r.holding;
      end else if (r.autoreset && r.alarm_flag) begin
         next_count = rtc_ctrl_pkg::WORD_RESET;
      end else if (r.counter_run) begin
         next_count = r.counter + 32'h0000_0001;
      end
   end

   // Strobes are one mclk wide; a write lands on the next edge
   always_comb begin
      next_r = r;
      next_r.sync = {r.sync[0], slow_osc_in};
      next_r.prev = r.sync[1];

      // Software access
      if (reg_wr) begin
         if (ctrl_sel) begin
            next_r.slow_osc_enable = reg_wdata[rtc_ctrl_pkg::OSC_EN_BIT];
            next_r.missing_clock_detect_enable =
               reg_wdata[rtc_ctrl_pkg::MCD_EN_BIT];
            if (!reg_wdata[rtc_ctrl_pkg::OSC_FAIL_BIT]) begin
               next_r.osc_failure_flag = 1'b0;
            end
            next_r.counter_run = reg_wdata[rtc_ctrl_pkg::RUN_BIT];
            next_r.alarm_enable = reg_wdata[rtc_ctrl_pkg::ALARM_EN_BIT];
            next_r.alarm_flag = 1'b0;
            next_r.autoreset = reg_wdata[rtc_ctrl_pkg::ALARM_AR_BIT];
            if (reg_wdata[rtc_ctrl_pkg::LOAD_BIT]) begin
               next_r.counter_load_request = 1'b1;
            end
            if (reg_wdata[rtc_ctrl_pkg::SNAP_BIT]) begin
               next_r.counter_snapshot_request = 1'b1;
            end
         end
         for (int k = 0; k < 4; k++) begin
            if (hold_sel[k]) begin
               next_r.holding[8*k +: 8] = reg_wdata;
            end
            if (match_sel[k]) begin
               next_r.match[8*k +: 8] = reg_wdata;
            end
         end
      end

      if (reg_rd) begin
         next_r.rdata = rd_view;
      end

      // Slow-clock work, one step per oscillator cycle
      if (tick) begin
         next_r.counter = next_count;
         if (r.counter_load_request) begin
            next_r.counter_load_request = 1'b0;
         end
         if (r.counter_snapshot_request) begin
            next_r.holding = r.counter;
            next_r.counter_snapshot_request = 1'b0;
         end
         // Flag lives one slow cycle; set wins over a same-cycle write
         next_r.alarm_flag = r.alarm_enable &&
                             (r.counter == r.match);
      end

      // Missing-clock detector; set wins over a same-cycle clear
      next_r.idle_cnt = next_idle;
      if (fail_set) begin
         next_r.osc_failure_flag = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign slow_osc_enable = r.slow_osc_enable;
   assign reg_rdata = r.rdata;
   assign alarm_event = r.alarm_flag;
   assign osc_failure_flag = r.osc_failure_flag;
endmodule

// ---- src/rtc_ctrl_pkg.sv ----
// Constants for the real-time clock control and counter logic.
// Assumes one processor-side clock at 40 MHz.
package rtc_ctrl_pkg;
   // Internal register addresses
   localparam logic [7:0] HOLD0_ADDR = 8'h00;
   localparam logic [7:0] HOLD3_ADDR = 8'h03;
   localparam logic [7:0] CTRL_ADDR = 8'h04;
   localparam logic [7:0] MATCH0_ADDR = 8'h08;
   localparam logic [7:0] MATCH3_ADDR = 8'h0b;
   // Control register bit positions
   localparam int OSC_EN_BIT = 7;
   localparam int MCD_EN_BIT = 6;
   localparam int OSC_FAIL_BIT = 5;
   localparam int RUN_BIT = 4;
   localparam int ALARM_EN_BIT = 3;
   localparam int ALARM_AR_BIT = 2;
   localparam int LOAD_BIT = 1;
   localparam int SNAP_BIT = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // Missing-clock timeout
   localparam int CLK_KHZ = 40000;
   localparam int MCD_TIME_US = 100;
   localparam int MCD_CYCLES_INT = MCD_TIME_US * CLK_KHZ / 1000;
   localparam int MCD_W = 13;
   localparam logic [MCD_W-1:0] MCD_CYCLES = MCD_CYCLES_INT[MCD_W-1:0];
endpackage

// ---- tb/rtc_ctrl_checker.sv ----
// Port assertions for the control and counter block.
// Assumes bind into rtc_ctrl; one clock, mclk.
`timescale 1ns/1ps
module rtc_ctrl_checker (
   // Clock, reset and pins
   input wire logic mclk, rst_n, slow_osc_in, slow_osc_enable,
   // Register port and events
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   input wire logic reg_wr, reg_rd, alarm_event, osc_failure_flag
);
   logic last;
   logic [12:0] held;
   wire cw = reg_wr && reg_addr == 8'h04;
   wire cr = reg_rd && reg_addr == 8'h04;
   // Cycles since the pin last changed
   always_ff @(posedge mclk) begin
      last <= slow_osc_in;
      if (!rst_n || last != slow_osc_in) held <= 13'h0;
      else held <= held + {12'h0, ~&held};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   osc_set_a: assert property
      (cw |=> slow_osc_enable == $past(reg_wdata[7])) else $error("osc");
   osc_keep_a: assert property
      (!cw |=> $stable(slow_osc_enable)) else $error("osc hold");
   fail_keep_a: assert property
      (osc_failure_flag && slow_osc_enable && !cw |=> osc_failure_flag)
      else $error("fail lost");
   fail_clr_a: assert property
      (cw && !reg_wdata[5] && reg_wdata[7] && held < 13'd3900
      |=> !osc_failure_flag) else $error("fail clear");
   fail_time_a: assert property
      ($rose(osc_failure_flag) |-> held > 13'd3990) else $error("early");
   fail_read_a: assert property
      (cr && slow_osc_enable |=> reg_rdata[5] == $past(osc_failure_flag))
      else $error("fail read");
   alarm_read_a: assert property
      (cr |=> reg_rdata[2] == $past(alarm_event)) else $error("alarm rd");
   alarm_clr_a: assert property
      (cw && held > 13'd3 |=> !alarm_event) else $error("alarm clr");
   cover property ($rose(alarm_event));
   cover property ($rose(osc_failure_flag));
   cover property (cr ##1 reg_rdata[2]);
endmodule
bind rtc_ctrl rtc_ctrl_checker chk_u (.mclk, .rst_n, .slow_osc_in,
   .slow_osc_enable, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr,
   .reg_rd, .alarm_event, .osc_failure_flag);

// ---- tb/tb.sv ----
// Self-checking bench for the control and counter block.
// Assumes the checker binds itself; bench makes the slow pin.
`timescale 1ns/1ps
module tb;
   logic mclk = 0, rst_n = 0, slow_osc_in = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic slow_osc_enable, alarm_event, osc_failure_flag;
   int mismatches = 0, total_checks = 0, i;
   always #12.5 mclk = ~mclk;
   rtc_ctrl dut_u (.mclk, .rst_n, .slow_osc_in, .slow_osc_enable,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .alarm_event, .osc_failure_flag);
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge mclk);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1;
      @(negedge mclk);
      reg_rd = 0;
      d = reg_rdata;
   endtask
   // n slow oscillator cycles, each 4 clocks high then 4 low
   task automatic tk(input int n);
      repeat (n) begin
         slow_osc_in = 1;
         repeat (4) @(negedge mclk);
         slow_osc_in = 0;
         repeat (4) @(negedge mclk);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] v);
      for (int k = 0; k < 4; k++) wr(a + 8'(k), v[8*k +: 8]);
   endtask
   task automatic hold(output logic [31:0] w);
      logic [7:0] b;
      for (int k = 0; k < 4; k++) begin
         rd(8'(k), b);
         w[8*k +: 8] = b;
      end
   endtask
   initial begin
      logic [7:0] b;
      logic [31:0] w;
      repeat (8) @(negedge mclk);
      rst_n = 1;
      rd(8'h04, b);
      chk(b, 8'h00);
      put(8'h00, 32'hffff_fffe);
      wr(8'h04, 8'h82);
      chk(slow_osc_enable, 1'b1);
      tk(1);
      rd(8'h04, b);
      chk(b, 8'h80);
      wr(8'h04, 8'h81);
      tk(1);
      rd(8'h04, b);
      chk(b, 8'h80);
      hold(w);
      chk(w, 32'hffff_fffe);
      wr(8'h04, 8'h90);
      tk(3);
      wr(8'h04, 8'h91);
      tk(1);
      hold(w);
      chk(w, 32'h0000_0001);
      wr(8'h04, 8'h80);
      tk(2);
      wr(8'h04, 8'h81);
      tk(1);
      hold(w);
      chk(w, 32'h0000_0002);
      put(8'h08, 32'h0000_0005);
      rd(8'h08, b);
      chk(b, 8'h05);
      wr(8'h04, 8'h9c);
      tk(4);
      chk(alarm_event, 1'b1);
      rd(8'h04, b);
      chk(b, 8'h9c);
      tk(1);
      chk(alarm_event, 1'b0);
      wr(8'h04, 8'h9d);
      tk(1);
      hold(w);
      chk(w, 32'h0000_0000);
      tk(5);
      wr(8'h04, 8'h98);
      chk(alarm_event, 1'b0);
      wr(8'h04, 8'h9c);
      rd(8'h04, b);
      chk(b, 8'h98);
      wr(8'h04, 8'hc0);
      tk(1);
      for (i = 0; i < 4100 && osc_failure_flag !== 1'b1; i++)
         @(negedge mclk);
      if (osc_failure_flag !== 1'b1) begin
         mismatches++;
         conclude();
      end
      chk(i > 3980 && i < 4010, 1'b1);
      tk(1);
      chk(osc_failure_flag, 1'b1);
      wr(8'h04, 8'hc0);
      chk(osc_failure_flag, 1'b0);
      conclude();
   end
endmodule
